// ---- rtl/sideband_regs.svh ----
// Purpose: Constants for the module-side sideband control block.
// Assumes: 20 MHz clock; times below are plain defaults.
// Notes:   Summary of operation follows.
// Summary of operation
// - Shared line is reset when host drives, interrupt when module drives.
// - Shared line is active low; both sides only pull it low.
// - Low pulse width tells interrupt (short) from reset (long).
// - Module interrupt pulse lies between minimum and maximum width.
// - Module releases line after every interrupt pulse, never holds it.
// - Host low past minimum reset width resets all user settings.
// - Initialisation interval starts when host releases the line.
// - Clear init-pending flag, then pulse interrupt to signal completion.
// - On power-up the completion interrupt is sent without host reset.
// - Presence line reads low while inserted, high while absent.
// - Receive lane at loss-of-signal level is muted, lane by lane.
// - Receive muting on by default; module-wide override may disable it.
// - Transmit lane at or below 50 mVpp is muted, loss flag set.
// - Transmit muting on by default; module-wide override may disable it.
// - Power class 0..5 encode 0.25, 1.0, 1.5, 2.5, 4.0, 6.0 W maxima.
// - Power class 6 means above 6 W; class 7 is reserved.
// - No draw above 6 W unless host enabled it explicitly.
`ifndef SIDEBAND_REGS_SVH
`define SIDEBAND_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_MHZ          20
`define INT_PW_MIN_US    5
`define INT_PW_MAX_US    20
`define INT_PULSE_US     10
`define INT_GAP_US       10
`define T_INIT_US        100
`define INT_PULSE_CYC    (`INT_PULSE_US * `CLK_MHZ)
`define INT_GAP_CYC      (`INT_GAP_US * `CLK_MHZ)
`define T_INIT_CYC       (`T_INIT_US * `CLK_MHZ)
`define RST_MIN_DEFAULT  16'h0fa0

// ----------------------------------------
// Lanes, squelch and power
// ----------------------------------------
`define LANES            12
`define TX_SIGNAL_LOST_MVPP      8'h32
`define PWR_CLASS_STD    3'h5
`define PWR_CLASS_HIGH   3'h6
`define PWR_CLASS_RSVD   3'h7
`define DNR_RESET        1'b1

`endif

// ---- rtl/sideband_pkg.sv ----
// Purpose: Types for the module-side sideband control block.
// Assumes: Nothing beyond the constants header.
// Notes:   State codes are written out.
`default_nettype none

package sideband_pkg;
  typedef enum logic [2:0] {
    ST_INIT     = 3'b000,
    ST_IRQ_LOW  = 3'b001,
    ST_IRQ_GAP  = 3'b010,
    ST_IDLE     = 3'b011,
    ST_HOST_RST = 3'b100
  } sb_state_e;

  typedef logic [7:0]  swing_t;
  typedef logic [11:0] timer_t;
endpackage : sideband_pkg

`default_nettype wire

// ---- rtl/lane_squelch.sv ----
// Purpose: One lane of receive and transmit loss-of-signal muting.
// Assumes: Swing input is the measured transmit input in mVpp.
// Notes:   Loss flag follows the input even with muting disabled.
`include "sideband_regs.svh"
`default_nettype none

module lane_squelch
  import sideband_pkg::*;
(
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Lane status
  input  wire logic   rx_signal_lost,
  input  wire swing_t tx_swing_mvpp,
  // Overrides
  input  wire logic   rx_squelch_disable,
  input  wire logic   tx_squelch_disable,
  // Lane controls
  output logic        rx_mute_q,
  output logic        tx_mute_q,
  output logic        tx_signal_lost_q
);

  logic tx_low;
  assign tx_low = (tx_swing_mvpp <= `TX_SIGNAL_LOST_MVPP);

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_mute_q <= 1'b0;
    end else begin
      rx_mute_q <= rx_signal_lost & ~rx_squelch_disable;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_mute_q        <= 1'b0;
      tx_signal_lost_q <= 1'b0;
    end else begin
      tx_mute_q        <= tx_low & ~tx_squelch_disable;
      tx_signal_lost_q <= tx_low;
    end
  end

  chk_rx_lane_mute: assert property (
    @(posedge clk) disable iff (rst)
    rx_signal_lost && !rx_squelch_disable |=> rx_mute_q)
    else $error("rx lane not muted on loss of signal");

  chk_tx_lane_mute: assert property (
    @(posedge clk) disable iff (rst)
    (tx_swing_mvpp <= 8'h32) && !tx_squelch_disable
      |=> tx_mute_q && tx_signal_lost_q)
    else $error("tx lane not muted or flag not set at low swing");

  chk_tx_override: assert property (
    @(posedge clk) disable iff (rst)
    tx_squelch_disable |=> !tx_mute_q)
    else $error("tx lane muted while override active");

endmodule : lane_squelch

`default_nettype wire

// ---- rtl/module_sideband.sv ----
// Purpose: Module-side sideband: shared interrupt/reset line, presence,
//          lane muting and power class gating.
// Assumes: All inputs synchronous to clk; shared line read as a level.
// Notes:   Shared line is open drain; the pad combines drive and enable.
`include "sideband_regs.svh"
`default_nettype none

module module_sideband
  import sideband_pkg::*;
(
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Shared interrupt/reset line
  input  wire logic                 sb_line_i,
  output logic                      sb_line_o,
  output logic                      sb_line_oe,
  // Presence
  output logic                      module_present_n,
  // Width threshold and events
  input  wire logic [15:0]          cfg_rst_min_cycles,
  input  wire logic                 status_event,
  // Management-written settings
  input  wire logic                 cfg_wr,
  input  wire logic                 cfg_rx_squelch_disable,
  input  wire logic                 cfg_tx_squelch_disable,
  input  wire logic                 cfg_high_power_enable,
  // Status toward management
  output logic                      data_not_ready_q,
  output logic                      user_defaults_q,
  output logic                      irq_pending_q,
  // Power class
  input  wire logic [2:0]           power_class_strap,
  output logic [2:0]                power_class_q,
  output logic                      high_power_allowed_q,
  // Lanes
  input  wire logic [`LANES-1:0]    rx_signal_lost,
  input  wire swing_t               tx_swing_mvpp [`LANES],
  output logic [`LANES-1:0]         rx_mute,
  output logic [`LANES-1:0]         tx_mute,
  output logic [`LANES-1:0]         tx_signal_lost
);

  localparam int INT_PW_M1 = `INT_PULSE_CYC - 1;

  sb_state_e           state_q;
  sb_state_e           state_d;
  timer_t              timer_q;
  logic [15:0]         lo_cnt_q;
  logic                rst_armed_q;
  logic                rx_sq_dis_q;
  logic                tx_sq_dis_q;
  logic                hp_en_q;
  logic                present_q;
  logic [`LANES-1:0]   tx_lost_prev_q;
  logic                host_low;
  logic                host_release;
  logic                take_irq;
  logic                new_loss;

  // ----------------------------------------
  // Shared line drive
  // ----------------------------------------
  // Data is always zero; only the enable moves, so the line is never
  // driven high and a host pulse always wins.
  assign sb_line_o  = 1'b0;
  assign sb_line_oe = (state_q == ST_IRQ_LOW);

  // ----------------------------------------
  // Host pulse timing
  // ----------------------------------------
  // Our own pulse is masked so it can never be taken for a host reset.
  assign host_low     = ~sb_line_i & ~sb_line_oe;
  assign host_release = (state_q == ST_HOST_RST) & sb_line_i;

  always_ff @(posedge clk) begin
    if (rst) begin
      lo_cnt_q <= 16'h0000;
    end else if (!host_low) begin
      lo_cnt_q <= 16'h0000;
    end else if (lo_cnt_q != 16'hffff) begin
      lo_cnt_q <= lo_cnt_q + 16'h0001;
    end
  end

  // No upper limit: once armed, the reset holds however long the host waits.
  always_ff @(posedge clk) begin
    if (rst) begin
      rst_armed_q <= 1'b0;
    end else if (host_release) begin
      rst_armed_q <= 1'b0;
    end else if (host_low && lo_cnt_q >= cfg_rst_min_cycles) begin
      rst_armed_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  assign take_irq = (state_q == ST_IDLE) & irq_pending_q;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_INIT: begin
        if (timer_q == 12'(`T_INIT_CYC - 1)) begin
          state_d = ST_IRQ_LOW;
        end
      end
      ST_IRQ_LOW: begin
        if (timer_q == 12'(`INT_PULSE_CYC - 1)) begin
          state_d = ST_IRQ_GAP;
        end
      end
      ST_IRQ_GAP: begin
        if (timer_q == 12'(`INT_GAP_CYC - 1)) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (take_irq) begin
          state_d = ST_IRQ_LOW;
        end
      end
      ST_HOST_RST: begin
        if (sb_line_i) begin
          state_d = ST_INIT;
        end
      end
      default: begin
        state_d = ST_INIT;
      end
    endcase
    if (rst_armed_q && state_q != ST_HOST_RST) begin
      state_d = ST_HOST_RST;
    end
  end

  // Power-up starts in the init interval, so completion is reported
  // without any host pulse.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_INIT;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state_d != state_q) begin
      timer_q <= 12'h000;
    end else if (state_q != ST_IDLE && state_q != ST_HOST_RST) begin
      timer_q <= timer_q + 12'h001;
    end
  end

  // ----------------------------------------
  // Init-pending flag and interrupt request
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      data_not_ready_q <= `DNR_RESET;
    end else if (state_d == ST_HOST_RST || state_d == ST_INIT) begin
      data_not_ready_q <= 1'b1;
    end else if (state_q == ST_INIT) begin
      data_not_ready_q <= 1'b0;
    end
  end

  assign new_loss = |(tx_signal_lost & ~tx_lost_prev_q);

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_lost_prev_q <= '0;
    end else begin
      tx_lost_prev_q <= tx_signal_lost;
    end
  end

  // A new event in the cycle the request is taken stays pending.
  always_ff @(posedge clk) begin
    if (rst || state_d == ST_HOST_RST) begin
      irq_pending_q <= 1'b0;
    end else begin
      irq_pending_q <= status_event | new_loss | (irq_pending_q & ~take_irq);
    end
  end

  // ----------------------------------------
  // User settings
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst || host_release) begin
      rx_sq_dis_q     <= 1'b0;
      tx_sq_dis_q     <= 1'b0;
      hp_en_q         <= 1'b0;
      user_defaults_q <= 1'b1;
    end else if (cfg_wr) begin
      rx_sq_dis_q     <= cfg_rx_squelch_disable;
      tx_sq_dis_q     <= cfg_tx_squelch_disable;
      hp_en_q         <= cfg_high_power_enable;
      user_defaults_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Presence and power class
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      present_q <= 1'b0;
    end else begin
      present_q <= 1'b0;
    end
  end
  assign module_present_n = present_q;

  // Strap caught by the clock, so reset never loads a port value directly.
  always_ff @(posedge clk) begin
    if (rst) begin
      power_class_q <= 3'h0;
    end else begin
      power_class_q <= power_class_strap;
    end
  end

  // Reserved class never gets high power, even with the enable set.
  always_ff @(posedge clk) begin
    if (rst) begin
      high_power_allowed_q <= 1'b0;
    end else begin
      high_power_allowed_q <= (power_class_q <= `PWR_CLASS_STD) ||
        (power_class_q == `PWR_CLASS_HIGH && hp_en_q);
    end
  end

  // ----------------------------------------
  // Lanes
  // ----------------------------------------
  for (genvar i = 0; i < `LANES; i++) begin : g_lane
    lane_squelch u_lane (
      .clk                (clk),
      .rst                (rst),
      .rx_signal_lost     (rx_signal_lost[i]),
      .tx_swing_mvpp      (tx_swing_mvpp[i]),
      .rx_squelch_disable (rx_sq_dis_q),
      .tx_squelch_disable (tx_sq_dis_q),
      .rx_mute_q          (rx_mute[i]),
      .tx_mute_q          (tx_mute[i]),
      .tx_signal_lost_q   (tx_signal_lost[i])
    );
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_irq_pulse_width: assert property (
    @(posedge clk) disable iff (rst)
    $rose(sb_line_oe) |-> ##INT_PW_M1 sb_line_oe ##1 !sb_line_oe)
    else $error("interrupt pulse width wrong");
  chk_irq_release_gap: assert property (
    @(posedge clk) disable iff (rst)
    $fell(sb_line_oe) |-> !sb_line_oe [*8])
    else $error("line not released after interrupt");
  chk_reset_detect: assert property (
    @(posedge clk) disable iff (rst)
    host_low && lo_cnt_q >= cfg_rst_min_cycles && !host_release
      |=> rst_armed_q)
    else $error("long host pulse not taken as reset");
  chk_init_on_release: assert property (
    @(posedge clk) disable iff (rst)
    state_q == ST_HOST_RST && sb_line_i
      |=> state_q == ST_INIT && data_not_ready_q && timer_q == 12'h000)
    else $error("init interval not started at release");
  chk_defaults_restore: assert property (
    @(posedge clk) disable iff (rst)
    host_release |=> !rx_sq_dis_q && !tx_sq_dis_q && !hp_en_q)
    else $error("settings not restored by host reset");
  chk_done_interrupt: assert property (
    @(posedge clk) disable iff (rst)
    $fell(data_not_ready_q) |-> $rose(sb_line_oe))
    else $error("completion not followed by interrupt");
  chk_powerup_flag: assert property (@(posedge clk)
    $fell(rst) |-> data_not_ready_q && state_q == ST_INIT)
    else $error("power-up did not start init interval");
  chk_present_low: assert property (
    @(posedge clk) disable iff (rst)
    $past(rst) == 1'b0 |-> !module_present_n)
    else $error("presence line not low while inserted");
  chk_high_power: assert property (
    @(posedge clk) disable iff (rst)
    high_power_allowed_q && $past(power_class_q) >= 3'h6
      |-> $past(power_class_q) == 3'h6 && $past(hp_en_q))
    else $error("high power without host enable");

endmodule : module_sideband

`default_nettype wire

// ---- test/host_line_model.sv ----
// Purpose: Host side of the shared line: pull-up, host pull, pulse timing.
// Assumes: Module drive is open drain, low while its enable is high.
// Notes:   Only low pulses inside the interrupt window count as interrupts.
`include "sideband_regs.svh"
`default_nettype none

module host_line_model (
  // Clock and reset
  input  wire logic   clk,
  input  wire logic   rst,
  // Shared line
  input  wire logic   host_pull,
  input  wire logic   mod_oe,
  input  wire logic   mod_o,
  output logic        line,
  // Management view
  input  wire logic   status_dnr,
  output int          irq_count,
  output logic [15:0] irq_width,
  output logic        status_ok
);
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WMIN = `INT_PW_MIN_US * `CLK_MHZ;
  localparam int WMAX = `INT_PW_MAX_US * `CLK_MHZ;

  logic [15:0] lo_cnt;
  logic        mod_low;

  // Wired low with pull-up: nobody pulling means high
  assign mod_low = mod_oe & ~mod_o;
  assign line    = ~(host_pull | mod_low);

  // Pulses are timed on our own clock, so the count is ours, not the module's
  always_ff @(posedge clk) begin
    if (rst) begin
      lo_cnt    <= '0;
      irq_count <= 0;
      irq_width <= '0;
      status_ok <= 1'b0;
    end else if (host_pull) begin
      lo_cnt    <= '0;
      status_ok <= 1'b0;
    end else if (!line) begin
      lo_cnt <= lo_cnt + 16'h0001;
    end else if (lo_cnt != 16'h0000) begin
      lo_cnt    <= '0;
      irq_width <= lo_cnt;
      if (int'(lo_cnt) > WMIN && int'(lo_cnt) < WMAX) begin
        irq_count <= irq_count + 1;
        status_ok <= ~status_dnr;
      end
    end
  end
endmodule : host_line_model

`default_nettype wire

// ---- test/pluggable_module_sideband_control_bench.sv ----
// Purpose: Self-checking bench for the module-side sideband block.
// Assumes: Host drives the shared line through the host line model.
// Notes:   Completion delay allows a few cycles of pipeline slack.
`include "sideband_regs.svh"
`default_nettype none

module pluggable_module_sideband_control_bench
  import sideband_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, host_pull, sb_o, oe, present_n, status_event;
  logic        cfg_wr, rx_dis_in, tx_dis_in, hp_en, dnr, user_def, irq_pend;
  logic        hp_ok, line, status_ok, rx_dis, tx_dis;
  logic [15:0] rst_min, irq_width;
  logic [2:0]  pclass, pclass_q;
  logic [11:0] rx_lost, rx_mute, tx_mute, tx_lost;
  swing_t      swing [`LANES];
  int          irq_count, n_mismatch, num_checks;

  initial clk = 1'b0;
  always #25 clk = ~clk;

  module_sideband uut (
    .clk(clk), .rst(rst), .sb_line_i(line), .sb_line_o(sb_o),
    .sb_line_oe(oe), .module_present_n(present_n),
    .cfg_rst_min_cycles(rst_min), .status_event(status_event),
    .cfg_wr(cfg_wr), .cfg_rx_squelch_disable(rx_dis_in),
    .cfg_tx_squelch_disable(tx_dis_in), .cfg_high_power_enable(hp_en),
    .data_not_ready_q(dnr), .user_defaults_q(user_def),
    .irq_pending_q(irq_pend), .power_class_strap(pclass),
    .power_class_q(pclass_q), .high_power_allowed_q(hp_ok),
    .rx_signal_lost(rx_lost), .tx_swing_mvpp(swing), .rx_mute(rx_mute),
    .tx_mute(tx_mute), .tx_signal_lost(tx_lost));

  host_line_model host (
    .clk(clk), .rst(rst), .host_pull(host_pull), .mod_oe(oe),
    .mod_o(sb_o), .line(line), .status_dnr(dnr), .irq_count(irq_count),
    .irq_width(irq_width), .status_ok(status_ok));

  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up

  task automatic cmp_vec(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp_vec

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_vec({15'h0000, got}, {15'h0000, exp});
  endtask : cmp_bit

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  // Bounded wait; running out of cycles ends the run
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while (oe !== lvl && n <= 3000) begin
      @(negedge clk);
      n++;
    end
    if (n > 3000) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, oe, lvl);
      wrap_up();
    end
  endtask : wait_oe

  task automatic check_irq(input int lo, input int hi);
    int n;
    int c0;
    c0 = irq_count;
    wait_oe(1'b1, n);
    cmp_bit(n >= lo && n <= hi, 1'b1);
    cmp_bit(dnr, 1'b0);
    cmp_bit(sb_o, 1'b0);
    wait_oe(1'b0, n);
    cmp_vec(16'(n), 16'h00c8);
    tick(2);
    cmp_vec(irq_width, 16'h00c8);
    cmp_bit(irq_count == c0 + 1, 1'b1);
    cmp_bit(status_ok, 1'b1);
  endtask : check_irq

  task automatic set_cfg(input logic rd, input logic td, input logic hp);
    cfg_wr    = 1'b1;
    rx_dis_in = rd;
    tx_dis_in = td;
    hp_en     = hp;
    tick(1);
    cfg_wr = 1'b0;
    rx_dis = rd;
    tx_dis = td;
    tick(3);
  endtask : set_cfg

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int          i;
    int          c;
    int          e;
    logic [11:0] exp_lost;
    rst          = 1'b1;
    host_pull    = 1'b0;
    status_event = 1'b0;
    cfg_wr       = 1'b0;
    rx_dis_in    = 1'b0;
    tx_dis_in    = 1'b0;
    hp_en        = 1'b0;
    rst_min      = 16'h0040;
    pclass       = 3'h0;
    rx_lost      = '0;
    rx_dis       = 1'b0;
    tx_dis       = 1'b0;
    foreach (swing[k]) swing[k] = 8'h80;
    void'($urandom(32'h6598));
    tick(2);
    rst = 1'b0;
    cmp_bit(present_n, 1'b0);
    cmp_bit(user_def, 1'b1);
    cmp_bit(dnr, 1'b1);
    check_irq(1999, 2003);
    // Event raised in the gap waits until the gap is over
    status_event = 1'b1;
    tick(1);
    status_event = 1'b0;
    cmp_bit(irq_pend, 1'b1);
    check_irq(197, 199);
    tick(250);
    // Event raised while idle is latched on the next edge and pulsed on the edge after
    status_event = 1'b1;
    tick(1);
    status_event = 1'b0;
    cmp_bit(irq_pend, 1'b1);
    check_irq(1, 3);
    cmp_bit(irq_pend, 1'b0);
    tick(250);
    set_cfg(1'b1, 1'b1, 1'b0);
    cmp_bit(user_def, 1'b0);
    // Too short for a reset: must leave settings alone
    host_pull = 1'b1;
    tick(int'(rst_min) - 8);
    host_pull = 1'b0;
    tick(10);
    cmp_bit(user_def, 1'b0);
    host_pull = 1'b1;
    tick(int'(rst_min) + 10);
    cmp_bit(dnr, 1'b1);
    cmp_bit(status_ok, 1'b0);
    host_pull = 1'b0;
    check_irq(1999, 2003);
    cmp_bit(user_def, 1'b1);
    rx_dis = 1'b0;
    tx_dis = 1'b0;
    // Swings cluster on the 50 mVpp boundary
    for (i = 0; i < 48; i++) begin
      if (i % 16 == 15) begin
        set_cfg(1'($urandom), 1'($urandom), 1'b0);
      end
      rx_lost = 12'($urandom);
      foreach (swing[k]) begin
        swing[k] = (i % 4 == 0) ? 8'($urandom) : 8'h30 + 8'($urandom % 5);
        exp_lost[k] = (swing[k] <= 8'h32);
      end
      tick(1);
      cmp_vec(16'(tx_lost), 16'(exp_lost));
      cmp_vec(16'(tx_mute), 16'(exp_lost & {12{~tx_dis}}));
      cmp_vec(16'(rx_mute), 16'(rx_lost & {12{~rx_dis}}));
    end
    for (c = 0; c < 8; c++) begin
      for (e = 0; e < 2; e++) begin
        pclass = 3'(c);
        set_cfg(rx_dis, tx_dis, 1'(e));
        cmp_vec(16'(pclass_q), 16'(c));
        cmp_bit(hp_ok, c <= 5 || (c == 6 && e == 1));
      end
    end
    wrap_up();
  end
endmodule : pluggable_module_sideband_control_bench

`default_nettype wire
